// ---- rtl/piosu_pkg.sv ----
// package: port map, field layouts and timing for the port/strobe unit
package piosu_pkg;
    localparam logic [3:0] PIOSU_ADDR_PORT0 = 4'h0;
    localparam logic [3:0] PIOSU_ADDR_PORT1 = 4'h1;
    localparam logic [3:0] PIOSU_ADDR_PORT4 = 4'h4;
    localparam logic [3:0] PIOSU_ADDR_PORT5 = 4'h5;
    localparam logic [3:0] PIOSU_ADDR_ICTL  = 4'h6;
    localparam logic [3:0] PIOSU_ADDR_TIMER = 4'h7;
    localparam logic [7:0] PIOSU_PORT_RESET = 8'h00;
    localparam logic [7:0] PIOSU_ICTL_RESET = 8'h00;
    localparam logic [7:0] PIOSU_TMR_RESET  = 8'h00;
    // pin-connected bits per port: port0 bit7, port1 bits 1-3, ports 4/5 all
    localparam logic [7:0] PIOSU_PIN_MASK0  = 8'h80;
    localparam logic [7:0] PIOSU_PIN_MASK1  = 8'h0E;
    // interrupt control fields
    localparam int PIOSU_ICTL_EXT_EN  = 0;
    localparam int PIOSU_ICTL_TMR_EN  = 1;
    localparam int PIOSU_ICTL_POL     = 2;
    localparam int PIOSU_ICTL_MODE_LO = 3;
    localparam int PIOSU_ICTL_RUN     = 5;
    localparam int PIOSU_ICTL_TMR_PND = 6;
    localparam int PIOSU_ICTL_EXT_PND = 7;
    // strobe low time in internal phase clocks (8..12 allowed)
    localparam int PIOSU_STB_LOW_PHI  = 8;
    localparam int PIOSU_STB_DLY_PHI  = 3;
    localparam logic [4:0] PIOSU_STB_LOW_CNT = 5'(PIOSU_STB_LOW_PHI * 2);
    localparam logic [4:0] PIOSU_STB_DLY_CNT = 5'(PIOSU_STB_DLY_PHI * 2);
    localparam logic [11:0] PIOSU_RESET_VECTOR = 12'h000;
    // output type per bit of ports 4 and 5, fixed at manufacture
    localparam logic [7:0] PIOSU_P4_DIRECT = 8'h00;
    localparam logic [7:0] PIOSU_P5_DIRECT = 8'h00;

    typedef enum logic [1:0] { TM_INTERVAL, TM_PULSE, TM_EVENT, TM_STOP } piosu_tmode_t;
    typedef enum { ST_IDLE, ST_DELAY, ST_LOW } piosu_stb_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [3:0] addr;
        logic [7:0] data;
    } piosu_io_t;
endpackage

// ---- rtl/piosu_top.sv ----
// top: parallel ports, ready strobe, external interrupt, timer gating, phase clock
`timescale 1ns/1ps
// Overview of operation
// [R01] strobe idles high, pulses low after port4 output
// [R02] strobe also pulses after port4 input
// [R03] held in reset while low, then fetch zero
// [R04] interrupt recognised only at selected polarity
// [R05] interrupt input gates timer or counts events
// [R06] interval mode timer ignores interrupt input
// [R07] two vectored interrupts, timer has priority
// [R08] each pin bit independent input or latch
// [R09] four 8-bit ports, unpinned bits are storage
// [R10] port 6 interrupt control, port 7 timer
// [R11] zero latch turns off pull-down driver
// [R12] phase clock is half time base rate
// [R13] ports 0,1 standard; 4,5 type per bit
module piosu_top
    import piosu_pkg::*;
(
    input  wire logic        MCLK_I,
    input  wire logic        ARST_N_I,
    input  wire logic        IO_WR_I,
    input  wire logic        IO_RD_I,
    input  wire logic [3:0]  IO_ADDR_I,
    input  wire logic [7:0]  IO_WDATA_I,
    output logic      [7:0]  IO_RDATA_O,
    input  wire logic [7:0]  P0_PIN_I,
    input  wire logic [7:0]  P1_PIN_I,
    input  wire logic [7:0]  PORT_FOUR_PINS_I,
    input  wire logic [7:0]  P5_PIN_I,
    output logic      [7:0]  P0_PIN_O,
    output logic      [7:0]  P1_PIN_O,
    output logic      [7:0]  PORT_FOUR_PINS_O,
    output logic      [7:0]  P5_PIN_O,
    output logic      [7:0]  P0_PIN_OE_N_O,
    output logic      [7:0]  P1_PIN_OE_N_O,
    output logic      [7:0]  PORT_FOUR_PINS_OE_N_O,
    output logic      [7:0]  P5_PIN_OE_N_O,
    output logic             STROBE_N_O,
    input  wire logic        EXT_INT_I,
    output logic             IRQ_O,
    output logic      [1:0]  IRQ_VECTOR_O,
    output logic             CORE_RESET_O,
    output logic      [11:0] FETCH_ADDR_O,
    output logic             INTERNAL_PHASE_CLOCK_O
);

    ////////////////////////////////////////////////////////////////////////
    piosu_io_t    io;
    logic [7:0]   port0_reg, port1_reg, port4_reg, port5_reg;
    logic [7:0]   ictl_reg, timer_reg, timer_load_reg;
    logic         ext_prev_reg;
    logic [4:0]   stb_cnt_reg;
    piosu_stb_t   stb_state_reg;
    logic         rst_hold_reg;
    piosu_tmode_t tmode;
    logic         ext_active, ext_edge, tmr_tick, tmr_zero;

    assign io = '{wr: IO_WR_I, rd: IO_RD_I, addr: IO_ADDR_I, data: IO_WDATA_I};
    assign tmode = piosu_tmode_t'(ictl_reg[PIOSU_ICTL_MODE_LO +: 2]);
    assign ext_active = EXT_INT_I ~^ ictl_reg[PIOSU_ICTL_POL]; // [R04]
    assign ext_edge = ext_active & ~ext_prev_reg;

    // pins: open pull-down, driving low only where the latch holds one
    function automatic logic [7:0] drive_en_n(input logic [7:0] latch, input logic [7:0] mask);
        drive_en_n = ~(latch & mask); // [R11] [R08]
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // port latches, all eight bits stored [R09]
    always_ff @(posedge MCLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
        begin
            port0_reg <= PIOSU_PORT_RESET;
            port1_reg <= PIOSU_PORT_RESET;
            port4_reg <= PIOSU_PORT_RESET;
            port5_reg <= PIOSU_PORT_RESET;
        end
        else if (io.wr)
        begin
            case (io.addr)
                PIOSU_ADDR_PORT0: port0_reg <= io.data;
                PIOSU_ADDR_PORT1: port1_reg <= io.data;
                PIOSU_ADDR_PORT4: port4_reg <= io.data;
                PIOSU_ADDR_PORT5: port5_reg <= io.data;
                default: ;
            endcase
        end
    end

    // pin drivers; ports 4/5 direct-drive bits push high too [R13]
    always_ff @(posedge MCLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
        begin
            P0_PIN_O <= 8'h00;
            P1_PIN_O <= 8'h00;
            PORT_FOUR_PINS_O <= 8'h00;
            P5_PIN_O <= 8'h00;
            P0_PIN_OE_N_O <= 8'hFF;
            P1_PIN_OE_N_O <= 8'hFF;
            PORT_FOUR_PINS_OE_N_O <= 8'hFF;
            P5_PIN_OE_N_O <= 8'hFF;
        end
        else
        begin
            P0_PIN_O <= 8'h00;
            P1_PIN_O <= 8'h00;
            PORT_FOUR_PINS_O <= port4_reg & PIOSU_P4_DIRECT;
            P5_PIN_O <= port5_reg & PIOSU_P5_DIRECT;
            P0_PIN_OE_N_O <= drive_en_n(port0_reg, PIOSU_PIN_MASK0);
            P1_PIN_OE_N_O <= drive_en_n(port1_reg, PIOSU_PIN_MASK1);
            PORT_FOUR_PINS_OE_N_O <= drive_en_n(port4_reg, 8'hFF) & ~PIOSU_P4_DIRECT; // [R13]
            P5_PIN_OE_N_O <= drive_en_n(port5_reg, 8'hFF) & ~PIOSU_P5_DIRECT;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read mux: pinned bits read the pin, others read the latch [R10]
    always_ff @(posedge MCLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
            IO_RDATA_O <= 8'h00;
        else if (io.rd)
        begin
            case (io.addr)
                PIOSU_ADDR_PORT0: IO_RDATA_O <= (P0_PIN_I & PIOSU_PIN_MASK0) | (port0_reg & ~PIOSU_PIN_MASK0);
                PIOSU_ADDR_PORT1: IO_RDATA_O <= (P1_PIN_I & PIOSU_PIN_MASK1) | (port1_reg & ~PIOSU_PIN_MASK1);
                PIOSU_ADDR_PORT4: IO_RDATA_O <= PORT_FOUR_PINS_I;
                PIOSU_ADDR_PORT5: IO_RDATA_O <= P5_PIN_I;
                PIOSU_ADDR_ICTL:  IO_RDATA_O <= ictl_reg;
                PIOSU_ADDR_TIMER: IO_RDATA_O <= timer_reg;
                default:          IO_RDATA_O <= 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // ready strobe: delay, then low for a fixed time [R01] [R02]
    always_ff @(posedge MCLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
        begin
            stb_state_reg <= ST_IDLE;
            stb_cnt_reg   <= 5'h00;
            STROBE_N_O    <= 1'b1;
        end
        else
        begin
            case (stb_state_reg)
                ST_IDLE:
                begin
                    STROBE_N_O <= 1'b1;
                    if ((io.wr || io.rd) && io.addr == PIOSU_ADDR_PORT4) // [R01] [R02]
                    begin
                        stb_state_reg <= ST_DELAY;
                        stb_cnt_reg   <= PIOSU_STB_DLY_CNT;
                    end
                end
                ST_DELAY:
                begin
                    if (stb_cnt_reg == 5'h01)
                    begin
                        stb_state_reg <= ST_LOW;
                        stb_cnt_reg   <= PIOSU_STB_LOW_CNT;
                        STROBE_N_O    <= 1'b0;
                    end
                    else
                        stb_cnt_reg <= stb_cnt_reg - 5'h01;
                end
                ST_LOW:
                begin
                    if (stb_cnt_reg == 5'h01)
                    begin
                        stb_state_reg <= ST_IDLE;
                        STROBE_N_O    <= 1'b1;
                    end
                    else
                        stb_cnt_reg <= stb_cnt_reg - 5'h01;
                end
                default: stb_state_reg <= ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // binary timer: counts down, reloads from the written value
    always_comb
    begin
        case (tmode)
            TM_INTERVAL: tmr_tick = ictl_reg[PIOSU_ICTL_RUN];              // [R06]
            TM_PULSE:    tmr_tick = ictl_reg[PIOSU_ICTL_RUN] & ext_active; // [R05]
            TM_EVENT:    tmr_tick = ictl_reg[PIOSU_ICTL_RUN] & ext_edge;   // [R05]
            default:     tmr_tick = 1'b0;
        endcase
    end
    assign tmr_zero = tmr_tick && timer_reg == 8'h01;

    always_ff @(posedge MCLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
        begin
            timer_reg      <= PIOSU_TMR_RESET;
            timer_load_reg <= PIOSU_TMR_RESET;
        end
        else if (io.wr && io.addr == PIOSU_ADDR_TIMER) // [R10]
        begin
            timer_reg      <= io.data;
            timer_load_reg <= io.data;
        end
        else if (tmr_zero)
            timer_reg <= timer_load_reg;
        else if (tmr_tick)
            timer_reg <= timer_reg - 8'h01;
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt control; a pending set wins over a software clear
    always_ff @(posedge MCLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
        begin
            ictl_reg     <= PIOSU_ICTL_RESET;
            ext_prev_reg <= 1'b0;
        end
        else
        begin
            ext_prev_reg <= ext_active;
            if (io.wr && io.addr == PIOSU_ADDR_ICTL) // [R10]
                ictl_reg <= io.data;
            if (ext_edge && ictl_reg[PIOSU_ICTL_EXT_EN]) // [R04]
                ictl_reg[PIOSU_ICTL_EXT_PND] <= 1'b1;
            if (tmr_zero && ictl_reg[PIOSU_ICTL_TMR_EN])
                ictl_reg[PIOSU_ICTL_TMR_PND] <= 1'b1;
        end
    end

    // vector 1 = timer (higher), 2 = external [R07]
    always_ff @(posedge MCLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
        begin
            IRQ_O        <= 1'b0;
            IRQ_VECTOR_O <= 2'h0;
        end
        else
        begin
            IRQ_O <= ictl_reg[PIOSU_ICTL_TMR_PND] | ictl_reg[PIOSU_ICTL_EXT_PND];
            if (ictl_reg[PIOSU_ICTL_TMR_PND])
                IRQ_VECTOR_O <= 2'h1; // [R07]
            else if (ictl_reg[PIOSU_ICTL_EXT_PND])
                IRQ_VECTOR_O <= 2'h2;
            else
                IRQ_VECTOR_O <= 2'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // reset release and phase clock divider [R03] [R12]
    always_ff @(posedge MCLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
        begin
            rst_hold_reg  <= 1'b1;
            CORE_RESET_O  <= 1'b1;
            FETCH_ADDR_O  <= PIOSU_RESET_VECTOR;
            INTERNAL_PHASE_CLOCK_O <= 1'b0;
        end
        else
        begin
            rst_hold_reg  <= 1'b0;
            CORE_RESET_O  <= rst_hold_reg;       // [R03]
            FETCH_ADDR_O  <= PIOSU_RESET_VECTOR; // [R03]
            INTERNAL_PHASE_CLOCK_O <= ~INTERNAL_PHASE_CLOCK_O; // [R12]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    a_strobe_after_wr: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I) // [R01]
        (stb_state_reg == ST_IDLE && io.wr && io.addr == PIOSU_ADDR_PORT4) |-> ##[6:8] !STROBE_N_O)
        else $error("strobe missing after port4 write");
    a_strobe_low_len: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I) // [R01]
        $fell(STROBE_N_O) |-> !STROBE_N_O [*8] ##[1:9] STROBE_N_O)
        else $error("strobe low time wrong");
    a_strobe_after_rd: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I) // [R02]
        (stb_state_reg == ST_IDLE && io.rd && !io.wr && io.addr == PIOSU_ADDR_PORT4) |-> ##[6:8] !STROBE_N_O)
        else $error("strobe missing after port4 read");
    a_reset_release: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I) // [R03]
        !CORE_RESET_O |-> FETCH_ADDR_O == 12'h000)
        else $error("fetch not at zero");
    a_ext_polarity: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I) // [R04]
        (ext_edge && ictl_reg[PIOSU_ICTL_EXT_EN]) |=> ictl_reg[PIOSU_ICTL_EXT_PND])
        else $error("external request lost");
    a_event_count: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I) // [R05]
        (tmode == TM_EVENT && !ext_edge && !(io.wr && io.addr == PIOSU_ADDR_TIMER)) |=> $stable(timer_reg))
        else $error("event counter moved without event");
    a_interval_run: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I) // [R06]
        (tmode == TM_INTERVAL && ictl_reg[PIOSU_ICTL_RUN] && timer_reg > 8'h01
         && !(io.wr && io.addr == PIOSU_ADDR_TIMER)) |=> timer_reg == $past(timer_reg) - 8'h01)
        else $error("interval timer stalled");
    a_irq_priority: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I) // [R07]
        ictl_reg[PIOSU_ICTL_TMR_PND] |=> IRQ_O && IRQ_VECTOR_O == 2'h1)
        else $error("timer vector not preferred");
    a_pulldown_off: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I) // [R11]
        (io.wr && io.addr == PIOSU_ADDR_PORT5 && io.data == 8'h00) |=> ##1 P5_PIN_OE_N_O == 8'hFF)
        else $error("pull-down still on");
    a_phase_half: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I) // [R12]
        INTERNAL_PHASE_CLOCK_O |=> !INTERNAL_PHASE_CLOCK_O)
        else $error("phase clock not halved");

    c_strobe: cover property (@(posedge MCLK_I) disable iff (!ARST_N_I) $rose(STROBE_N_O));
    c_ext_irq: cover property (@(posedge MCLK_I) disable iff (!ARST_N_I) IRQ_O && IRQ_VECTOR_O == 2'h2);
    c_tmr_irq: cover property (@(posedge MCLK_I) disable iff (!ARST_N_I) IRQ_O && IRQ_VECTOR_O == 2'h1);

endmodule

// ---- tb/piosu_periph.sv ----
// partner: peripherals on the port pins, open-drain style with pull-ups
`timescale 1ns/1ps
module piosu_periph
    import piosu_pkg::*;
(
    input  wire logic [3:0][7:0] oe_n_i,
    input  wire logic [3:0][7:0] pull_low_i,
    output logic      [3:0][7:0] pin_o
);
    ////////////////////////////////////////////////////////////////////////////////
    // wired-and: pull-up unless device or peripheral pulls low
    assign pin_o = oe_n_i & ~pull_low_i;
endmodule

// ---- tb/test_port_io_strobe_unit.sv ----
// bench: port/strobe unit register, pin, strobe and interrupt tests
`timescale 1ns/1ps
`define CHK(got, exp, msg) \
    begin \
        tests_run = tests_run + 1; \
        if ((got) !== (exp)) \
        begin \
            err_count = err_count + 1; \
            $display("ERROR %0t %s got %h exp %h", $time, msg, got, exp); \
        end \
    end
module test_port_io_strobe_unit
    import piosu_pkg::*;
;
    logic            mclk;
    logic            arst_n;
    logic            wr;
    logic            rd;
    logic [3:0]      addr;
    logic [7:0]      wdata;
    logic [7:0]      rdata;
    logic [3:0][7:0] pin;
    logic [3:0][7:0] drv_o;
    logic [3:0][7:0] oe_n;
    logic [3:0][7:0] pull_low;
    logic            strobe_n;
    logic            ext_int;
    logic            irq;
    logic [1:0]      vec;
    logic            core_rst;
    logic [11:0]     fetch;
    logic            phase;
    logic            p;
    logic [7:0]      rv;
    logic [7:0]      v;
    logic [3:0]      pa [4];
    logic [7:0]      pm [4];
    int              err_count;
    int              tests_run;
    int              d;
    int              l;

    piosu_top DUT (.MCLK_I(mclk), .ARST_N_I(arst_n), .IO_WR_I(wr), .IO_RD_I(rd), .IO_ADDR_I(addr),
        .IO_WDATA_I(wdata), .IO_RDATA_O(rdata), .P0_PIN_I(pin[0]), .P1_PIN_I(pin[1]),
        .PORT_FOUR_PINS_I(pin[2]), .P5_PIN_I(pin[3]), .P0_PIN_O(drv_o[0]), .P1_PIN_O(drv_o[1]),
        .PORT_FOUR_PINS_O(drv_o[2]), .P5_PIN_O(drv_o[3]), .P0_PIN_OE_N_O(oe_n[0]), .P1_PIN_OE_N_O(oe_n[1]),
        .PORT_FOUR_PINS_OE_N_O(oe_n[2]), .P5_PIN_OE_N_O(oe_n[3]), .STROBE_N_O(strobe_n), .EXT_INT_I(ext_int),
        .IRQ_O(irq), .IRQ_VECTOR_O(vec), .CORE_RESET_O(core_rst), .FETCH_ADDR_O(fetch),
        .INTERNAL_PHASE_CLOCK_O(phase));
    piosu_periph u_periph (.oe_n_i(oe_n), .pull_low_i(pull_low), .pin_o(pin));

    initial
    begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic summarize();
        $display("counts: %0d compares, %0d mismatches", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task automatic wr_port(input logic [3:0] a, input logic [7:0] dv);
        tick(1);
        wr = 1'b1;
        addr = a;
        wdata = dv;
        tick(1);
        wr = 1'b0;
    endtask

    task automatic rd_port(input logic [3:0] a, output logic [7:0] dv);
        tick(1);
        rd = 1'b1;
        addr = a;
        tick(1);
        rd = 1'b0;
        tick(1);
        dv = rdata;
    endtask

    // cycles until strobe falls, then cycles it stays low, both capped at 40
    task automatic strobe_pulse(output int dly, output int low);
        dly = 0;
        low = 0;
        while (strobe_n === 1'b1 && dly < 40)
        begin
            tick(1);
            dly++;
        end
        while (strobe_n === 1'b0 && low < 40)
        begin
            tick(1);
            low++;
        end
    endtask

    task automatic wait_irq();
        int i;
        i = 0;
        while (irq !== 1'b1 && i < 30)
        begin
            tick(1);
            i++;
        end
        if (i >= 30)
        begin
            err_count++;
            $display("ERROR %0t interrupt wait ran out", $time);
            summarize();
        end
    endtask

    task automatic ext_pulse();
        ext_int = 1'b1;
        tick(4);
        ext_int = 1'b0;
        tick(4);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        #2000000;
        err_count++;
        $display("ERROR %0t run did not finish", $time);
        summarize();
    end

    initial
    begin
        arst_n = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        addr = 4'h0;
        wdata = 8'h00;
        ext_int = 1'b0;
        pull_low = '0;
        err_count = 0;
        tests_run = 0;
        pa = '{PIOSU_ADDR_PORT0, PIOSU_ADDR_PORT1, PIOSU_ADDR_PORT4, PIOSU_ADDR_PORT5};
        pm = '{PIOSU_PIN_MASK0, PIOSU_PIN_MASK1, 8'hFF, 8'hFF};
        repeat (6) @(posedge mclk);
        #1;
        `CHK(core_rst, 1'b1, "core held in reset")
        `CHK(strobe_n, 1'b1, "strobe idle in reset")
        `CHK(oe_n, {32{1'b1}}, "pull-downs off in reset")
        arst_n = 1'b1;
        tick(3);
        `CHK(core_rst, 1'b0, "core released")
        `CHK(fetch, PIOSU_RESET_VECTOR, "fetch start address")
        p = phase;
        tick(1);
        `CHK(phase, ~p, "phase clock toggle")
        $display("test reset done");

        for (int k = 0; k < 4; k++)
        begin
            v = 8'h71 ^ {k[3:0], 4'h3};
            wr_port(pa[k], v);
            tick(2);
            `CHK(oe_n[k], ~(v & pm[k]), "pull-down per latched bit")
            rd_port(pa[k], rv);
            if (k < 2)
                `CHK(rv & ~pm[k], v & ~pm[k], "unpinned bits store")
            else
                `CHK(rv, ~v, "pinned port reads pins")
        end
        `CHK(drv_o[2], 8'h52 & PIOSU_P4_DIRECT, "port4 output type")
        `CHK(drv_o[3], 8'h42 & PIOSU_P5_DIRECT, "port5 output type")
        `CHK({drv_o[1], drv_o[0]}, 16'h0000, "standard outputs only")
        wr_port(PIOSU_ADDR_PORT4, 8'h00);
        pull_low[2] = 8'h3C;
        rd_port(PIOSU_ADDR_PORT4, rv);
        `CHK(rv, 8'hC3, "input after zero write")
        pull_low[2] = 8'h00;
        $display("test ports done");

        tick(40);
        wr_port(PIOSU_ADDR_PORT4, 8'h11);
        strobe_pulse(d, l);
        `CHK(d, PIOSU_STB_DLY_PHI * 2, "strobe after output")
        `CHK(l, PIOSU_STB_LOW_PHI * 2, "strobe low time")
        wr_port(PIOSU_ADDR_PORT4, 8'h22);
        tick(8);
        wr_port(PIOSU_ADDR_PORT4, 8'h33);
        strobe_pulse(d, l);
        strobe_pulse(d, l);
        `CHK(d, 40, "single pulse per output")
        rd_port(PIOSU_ADDR_PORT4, rv);
        strobe_pulse(d, l);
        `CHK(l, 16, "strobe after input")
        $display("test strobe done");

        rd_port(4'h2, rv);
        `CHK(rv, 8'h00, "unmapped port")
        wr_port(PIOSU_ADDR_ICTL, 8'h04);
        rd_port(PIOSU_ADDR_ICTL, rv);
        `CHK(rv[5:0], 6'h04, "port 6 control")
        wr_port(PIOSU_ADDR_TIMER, 8'h03);
        ext_int = 1'b1;
        wr_port(PIOSU_ADDR_ICTL, 8'h01);
        tick(10);
        `CHK(irq, 1'b0, "inactive level ignored")
        ext_int = 1'b0;
        wait_irq();
        `CHK(vec, 2'd2, "active low interrupt")
        wr_port(PIOSU_ADDR_ICTL, 8'h05);
        tick(3);
        `CHK(irq, 1'b0, "pending cleared")
        ext_int = 1'b1;
        wait_irq();
        `CHK(vec, 2'd2, "active high interrupt")
        ext_int = 1'b0;
        wr_port(PIOSU_ADDR_ICTL, 8'h00);
        $display("test interrupt done");

        wr_port(PIOSU_ADDR_TIMER, 8'h03);
        wr_port(PIOSU_ADDR_ICTL, 8'h22);
        wait_irq();
        `CHK(vec, 2'd1, "interval timer alone")
        wr_port(PIOSU_ADDR_ICTL, 8'h00);
        wr_port(PIOSU_ADDR_TIMER, 8'h02);
        wr_port(PIOSU_ADDR_ICTL, 8'h37);
        tick(5);
        `CHK(irq, 1'b0, "event counter idle")
        ext_pulse();
        `CHK(vec, 2'd2, "first event ext only")
        ext_pulse();
        `CHK(vec, 2'd1, "timer wins priority")
        wr_port(PIOSU_ADDR_ICTL, 8'h00);
        wr_port(PIOSU_ADDR_TIMER, 8'h04);
        wr_port(PIOSU_ADDR_ICTL, 8'h2E);
        rd_port(PIOSU_ADDR_TIMER, rv);
        `CHK(rv, 8'h04, "pulse width idle while inactive")
        ext_int = 1'b1;
        tick(2);
        ext_int = 1'b0;
        rd_port(PIOSU_ADDR_TIMER, rv);
        `CHK(rv, 8'h02, "pulse width counts active cycles")
        $display("test timer done");
        summarize();
    end
endmodule
